// ==== include/acf_pkg.sv ====
// Package for the ALU condition-flag block: offsets, fields, operations
// Functional notes
// RULE1: Flag register is readable and writable like any other data register.
// RULE2: Flag-affecting op targeting the register updates its affected flags from ALU, not write.
// RULE3: Wipe op on flag register sets zero flag, other flags unchanged.
// RULE4: Software should alter flags only with bit, swap or copy operations.
// RULE5: Signed wrap bit 3 set when signed result overflows seven-bit magnitude.
// RULE6: Low-half-out set on carry from bit 3 in add and subtract.
// RULE7: Carry bit 0 set on carry-out from the top bit in add and subtract.
// RULE8: In subtraction carry and low-half-out mean no borrow when one.
// RULE9: Subtraction adds two's complement of second operand to first.
// RULE10: Sign bit 4 copies result top bit.
// RULE11: Zero bit 2 set on zero result; bits 7 to 5 read zero.
package acf_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [3:0] ACF_OFS_FLAGS  = 4'h0; // alu_status_flags
  localparam logic [3:0] ACF_OFS_OPA    = 4'h4; // operand A
  localparam logic [3:0] ACF_OFS_OPB    = 4'h8; // operand B
  localparam logic [3:0] ACF_OFS_CMD    = 4'hC; // command, write starts operation
  localparam logic [3:0] ACF_OFS_RESULT = 4'h0; // unused alias guard
  localparam logic [31:0] ACF_RD_UNMAPPED = 32'h00000000;
  // Field positions
  localparam int ACF_BIT_C    = 0;
  localparam int ACF_BIT_DC   = 1;
  localparam int ACF_BIT_Z    = 2;
  localparam int ACF_BIT_OV   = 3;
  localparam int ACF_BIT_N    = 4;
  localparam logic [7:0] ACF_FLAG_MASK = 8'h1F;
  localparam logic [7:0] ACF_RESET_VAL = 8'h00;
  // Command field: op in [3:0], dest-is-flags in [4]
  localparam int ACF_CMD_DST_BIT = 4;
  localparam logic [3:0] ACF_OP_ADD  = 4'h0;
  localparam logic [3:0] ACF_OP_SUB  = 4'h1;
  localparam logic [3:0] ACF_OP_AND  = 4'h2;
  localparam logic [3:0] ACF_OP_IOR  = 4'h3;
  localparam logic [3:0] ACF_OP_XOR  = 4'h4;
  localparam logic [3:0] ACF_OP_WIPE = 4'h5;
  localparam logic [3:0] ACF_OP_MOVE = 4'h6;
  localparam logic [3:0] ACF_OP_SWAP = 4'h7;
  localparam logic [3:0] ACF_OP_BCLR = 4'h8;
  localparam logic [3:0] ACF_OP_BSET = 4'h9;
endpackage

// ==== design/acf_alu_flags.sv ====
// ALU condition-flag logic with an Avalon-MM register slave
//
// The implementer's own choices: the address map and the Avalon-MM slave port.
`timescale 1ns/1ps
module acf_alu_flags
  import acf_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic [3:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o,
  output logic [7:0]       result_o,
  output logic [7:0]       flags_o
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0]  flags_r;
  logic [7:0]  opa_r;
  logic [7:0]  opb_r;
  logic [7:0]  result_r;
  logic [31:0] rdata_r;
  logic        ack_r;
  logic        wr_go;
  logic        rd_go;

  // One wait cycle per access keeps read data registered
  // Writes commit only in the second cycle, where waitrequest is low,
  // so a write that is still being stalled can never change state
  assign wr_go = avs_write_i && ack_r;
  assign rd_go = avs_read_i && !ack_r;
  assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack_r;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= (avs_read_i || avs_write_i) && !ack_r;
    end
  end

  // ----------------------------------------------------------------
  // ALU datapath
  // ----------------------------------------------------------------
  logic [3:0] cmd_op;
  logic       cmd_dst;
  logic [2:0] bit_sel;
  logic [7:0] b_eff;
  logic       c_in;
  logic [4:0] low_sum;
  logic [8:0] full_sum;
  logic [7:0] alu_res;
  logic       arith;
  logic       logic_op;

  assign cmd_op  = avs_writedata_i[3:0];
  assign cmd_dst = avs_writedata_i[ACF_CMD_DST_BIT];
  assign bit_sel = avs_writedata_i[10:8];

  // Subtraction as A + ~B + 1, so carries come out as inverted borrows
  always_comb begin
    b_eff = (cmd_op == ACF_OP_SUB) ? ~opb_r : opb_r; // RULE9
    c_in  = (cmd_op == ACF_OP_SUB);                   // RULE9
    low_sum  = {1'b0, opa_r[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, c_in};
    full_sum = {1'b0, opa_r} + {1'b0, b_eff} + {8'h00, c_in};
    arith    = (cmd_op == ACF_OP_ADD) || (cmd_op == ACF_OP_SUB);
    logic_op = (cmd_op == ACF_OP_AND) || (cmd_op == ACF_OP_IOR) || (cmd_op == ACF_OP_XOR);
    case (cmd_op)
      ACF_OP_ADD:  alu_res = full_sum[7:0];
      ACF_OP_SUB:  alu_res = full_sum[7:0];
      ACF_OP_AND:  alu_res = opa_r & opb_r;
      ACF_OP_IOR:  alu_res = opa_r | opb_r;
      ACF_OP_XOR:  alu_res = opa_r ^ opb_r;
      ACF_OP_WIPE: alu_res = 8'h00;
      ACF_OP_MOVE: alu_res = opa_r;
      ACF_OP_SWAP: alu_res = {opa_r[3:0], opa_r[7:4]};
      default:     alu_res = 8'h00;
    endcase
  end

  // Target byte when the flag register itself is the operand
  logic [7:0] tgt_src;
  logic [7:0] tgt_val;
  always_comb begin
    tgt_src = cmd_dst ? flags_r : opa_r; // RULE1
    case (cmd_op)
      ACF_OP_BCLR: tgt_val = tgt_src & ~(8'h01 << bit_sel);
      ACF_OP_BSET: tgt_val = tgt_src | (8'h01 << bit_sel);
      ACF_OP_SWAP: tgt_val = {tgt_src[3:0], tgt_src[7:4]};
      default:     tgt_val = alu_res;
    endcase
  end

  // ----------------------------------------------------------------
  // Flag register
  // ----------------------------------------------------------------
  logic [7:0] nflags;
  logic       cmd_hit;
  assign cmd_hit = wr_go && (avs_address_i == ACF_OFS_CMD);

  always_comb begin
    nflags = flags_r;
    if (wr_go && (avs_address_i == ACF_OFS_FLAGS) && avs_byteenable_i[0]) begin
      nflags = avs_writedata_i[7:0] & ACF_FLAG_MASK; // RULE1
    end else if (cmd_hit) begin
      // Non-flag ops write through when the flag register is destination
      if (cmd_dst && !arith && !logic_op && (cmd_op != ACF_OP_WIPE)) begin
        nflags = tgt_val & ACF_FLAG_MASK; // RULE1
      end
      if (arith) begin
        nflags[ACF_BIT_C]  = full_sum[8];  // RULE7 RULE8 RULE2
        nflags[ACF_BIT_DC] = low_sum[4];   // RULE6 RULE8
        nflags[ACF_BIT_OV] = (opa_r[7] == b_eff[7]) && (full_sum[7] != opa_r[7]); // RULE5
        nflags[ACF_BIT_N]  = full_sum[7];  // RULE10
      end
      if (arith || logic_op || (cmd_op == ACF_OP_WIPE)) begin
        nflags[ACF_BIT_Z] = (alu_res == 8'h00); // RULE11 RULE3 RULE2
      end
      if (logic_op) begin
        nflags[ACF_BIT_N] = alu_res[7]; // RULE10
      end
    end
  end

  // Upper bits are never stored, so they always read as zero
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flags_r <= ACF_RESET_VAL;
    end else begin
      flags_r <= nflags & ACF_FLAG_MASK; // RULE11
    end
  end

  // Operand registers
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      opa_r <= 8'h00;
      opb_r <= 8'h00;
    end else if (wr_go && avs_byteenable_i[0]) begin
      if (avs_address_i == ACF_OFS_OPA) begin
        opa_r <= avs_writedata_i[7:0];
      end else if (avs_address_i == ACF_OFS_OPB) begin
        opb_r <= avs_writedata_i[7:0];
      end
    end
  end

  // Result of the last command
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      result_r <= 8'h00;
    end else if (cmd_hit) begin
      result_r <= cmd_dst ? (nflags & ACF_FLAG_MASK) : tgt_val;
    end
  end

  // Read data, registered during the wait cycle
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_r <= 32'h00000000;
    end else if (rd_go) begin
      if (avs_address_i == ACF_OFS_FLAGS) begin
        rdata_r <= {24'h000000, flags_r}; // RULE1
      end else if (avs_address_i == ACF_OFS_OPA) begin
        rdata_r <= {24'h000000, opa_r};
      end else if (avs_address_i == ACF_OFS_OPB) begin
        rdata_r <= {24'h000000, opb_r};
      end else if (avs_address_i == ACF_OFS_CMD) begin
        rdata_r <= {24'h000000, result_r};
      end else begin
        rdata_r <= ACF_RD_UNMAPPED;
      end
    end
  end

  assign avs_readdata_o = rdata_r;
  assign result_o       = result_r;
  assign flags_o        = flags_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_upper_zero: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE11
    flags_o[7:5] == 3'b000) else $error("upper flag bits not zero");
  a_add_carry: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE7
    (cmd_hit && cmd_op == ACF_OP_ADD) |=> flags_o[0] == $past({1'b0, opa_r} + {1'b0, opb_r}) >> 8)
    else $error("add carry wrong");
  a_sub_borrow: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE8
    (cmd_hit && cmd_op == ACF_OP_SUB) |=> flags_o[0] == ($past(opa_r) >= $past(opb_r)))
    else $error("sub borrow wrong");
  a_sub_dborrow: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE6
    (cmd_hit && cmd_op == ACF_OP_SUB) |=> flags_o[1] == ($past(opa_r[3:0]) >= $past(opb_r[3:0])))
    else $error("sub digit borrow wrong");
  a_zero_set: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE11
    (cmd_hit && (arith || logic_op)) |=> flags_o[2] == ($past(alu_res) == 8'h00))
    else $error("zero flag wrong");
  a_wipe_zero: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE3
    (cmd_hit && cmd_op == ACF_OP_WIPE && cmd_dst) |=> (flags_o == ($past(flags_r) | 8'h04)))
    else $error("wipe on flags wrong");
  a_sign_copy: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE10
    (cmd_hit && arith && !cmd_dst) |=> flags_o[4] == result_o[7]) else $error("sign flag wrong");
  a_ovf_add: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE5
    (cmd_hit && cmd_op == ACF_OP_ADD && opa_r == 8'h7F && opb_r == 8'h01) |=> flags_o[3])
    else $error("overflow missed");
  a_protect: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE2
    (cmd_hit && cmd_op == ACF_OP_AND && cmd_dst && opa_r == 8'h00) |=> flags_o[2])
    else $error("flag write not blocked");
  a_swap_flags: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE1
    (cmd_hit && cmd_op == ACF_OP_SWAP && cmd_dst) |=>
    flags_o == ({$past(flags_r[3:0]), $past(flags_r[7:4])} & 8'h1F)) else $error("swap wrong");
  a_dc_add: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE6
    (cmd_hit && cmd_op == ACF_OP_ADD) |=> flags_o[1] == (({1'b0, $past(opa_r[3:0])} + {1'b0, $past(opb_r[3:0])}) > 5'h0F))
    else $error("add digit carry wrong");
  a_sub_wrap: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE5
    (cmd_hit && cmd_op == ACF_OP_SUB && !cmd_dst) |=>
    flags_o[3] == (($past(opa_r[7]) != $past(opb_r[7])) && (result_o[7] != $past(opa_r[7]))))
    else $error("subtract overflow wrong");
  a_logic_keep: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE2
    (cmd_hit && logic_op) |=> (flags_o[1:0] == $past(flags_r[1:0])) && (flags_o[3] == $past(flags_r[3])))
    else $error("logic op changed arithmetic flags");
  a_move_flags: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE1
    (cmd_hit && cmd_op == ACF_OP_MOVE && cmd_dst) |=> flags_o == ($past(opa_r) & 8'h1F))
    else $error("move into flags wrong");
endmodule

// ==== test/acf_testbench.sv ====
// Self-checking testbench for the ALU condition-flag block
`timescale 1ns/1ps
module testbench;
  import acf_pkg::*;
  // ----------------------------------------------------------
  // Signals and table rows
  // ----------------------------------------------------------
  typedef struct packed {
    logic [7:0]  pre;
    logic [10:0] cmd;
    logic [7:0]  a;
    logic [7:0]  b;
    logic [7:0]  res;
    logic [7:0]  flg;
  } acf_row_s;
  logic        clk_i;
  logic        rst_n_i;
  logic [3:0]  avs_address_i;
  logic        avs_read_i;
  logic        avs_write_i;
  logic [31:0] avs_writedata_i;
  logic [3:0]  avs_byteenable_i;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o;
  logic [7:0]  result_o;
  logic [7:0]  flags_o;
  int          mismatches = 0;
  int          check_count = 0;
  int          cycles = 0;
  logic [7:0]  rd;
  acf_row_s    rows [22];

  acf_alu_flags dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .result_o(result_o), .flags_o(flags_o));

  // ----------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Idle edge after release keeps one assignment per time step
  task automatic bus(input logic wr, input logic [3:0] adr, input logic [31:0] dat, input logic [3:0] be);
    avs_address_i <= adr;
    avs_writedata_i <= dat;
    avs_byteenable_i <= be;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    @(posedge clk_i);
    while (avs_waitrequest_o !== 1'b0) @(posedge clk_i);
    rd = avs_readdata_o[7:0];
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic end_sim;
    $display("Checks %0d, mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // ----------------------------------------------------------
  // Clock and hang guard
  // ----------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  // Whole run needs well under a thousand cycles
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      mismatches++;
      end_sim();
    end
  end

  // ----------------------------------------------------------
  // Stimulus
  // ----------------------------------------------------------
  initial begin
    rst_n_i = 1'b0;
    avs_address_i = 4'h0;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_writedata_i = 32'h0;
    avs_byteenable_i = 4'hF;
    // Preset flags, command {dest, op} plus bit number, operands, result, flags
    rows = '{'{8'h00, 11'h000, 8'h7F, 8'h01, 8'h80, 8'h1A},
             '{8'h10, 11'h000, 8'hFF, 8'h01, 8'h00, 8'h07},
             '{8'h00, 11'h000, 8'h80, 8'h80, 8'h00, 8'h0D},
             '{8'h00, 11'h001, 8'h05, 8'h03, 8'h02, 8'h03},
             '{8'h03, 11'h001, 8'h03, 8'h05, 8'hFE, 8'h10},
             '{8'h00, 11'h001, 8'h80, 8'h01, 8'h7F, 8'h09},
             '{8'h00, 11'h001, 8'h10, 8'h10, 8'h00, 8'h07},
             '{8'h1B, 11'h002, 8'hF0, 8'h0F, 8'h00, 8'h0F},
             '{8'h04, 11'h003, 8'h80, 8'h01, 8'h81, 8'h10},
             '{8'h13, 11'h004, 8'hAA, 8'hAA, 8'h00, 8'h07},
             '{8'h1B, 11'h005, 8'h55, 8'h00, 8'h00, 8'h1F},
             '{8'h15, 11'h006, 8'h3C, 8'h00, 8'h3C, 8'h15},
             '{8'h15, 11'h007, 8'h3C, 8'h00, 8'hC3, 8'h15},
             '{8'h15, 11'h308, 8'hFF, 8'h00, 8'hF7, 8'h15},
             '{8'h15, 11'h709, 8'h00, 8'h00, 8'h80, 8'h15},
             '{8'h1F, 11'h010, 8'h7F, 8'h01, 8'h00, 8'h1A},
             '{8'h1A, 11'h015, 8'h00, 8'h00, 8'h00, 8'h1E},
             '{8'h00, 11'h016, 8'hFF, 8'h00, 8'h00, 8'h1F},
             '{8'h1B, 11'h012, 8'h00, 8'hFF, 8'h00, 8'h0F},
             '{8'h15, 11'h017, 8'h00, 8'h00, 8'h00, 8'h11},
             '{8'h1F, 11'h218, 8'h00, 8'h00, 8'h00, 8'h1B},
             '{8'h00, 11'h419, 8'hA5, 8'h5A, 8'h00, 8'h10}};
    repeat (8) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    chk(flags_o, 8'h00);
    // Table rows: preset, operands, command, then compare
    foreach (rows[i]) begin
      bus(1'b1, ACF_OFS_FLAGS, {24'h000000, rows[i].pre}, 4'hF);
      bus(1'b1, ACF_OFS_OPA, {24'h000000, rows[i].a}, 4'hF);
      bus(1'b1, ACF_OFS_OPB, {24'h000000, rows[i].b}, 4'hF);
      bus(1'b1, ACF_OFS_CMD, {21'h000000, rows[i].cmd}, 4'hF);
      // Bit ops repeat with lane 0 off: the command ignores byte enables
      if (rows[i].cmd[10:8] != 3'h0) bus(1'b1, ACF_OFS_CMD, {21'h000000, rows[i].cmd}, 4'hE);
      if (rows[i].cmd[4] == 1'b0) chk(result_o, rows[i].res);
      chk(flags_o, rows[i].flg);
      bus(1'b0, ACF_OFS_FLAGS, 32'h00000000, 4'hF);
      chk(rd, rows[i].flg);
      $display("Row %0d done", i);
    end
    // Readback of last result and both operands, lane 1 of the result zero
    bus(1'b0, ACF_OFS_CMD, 32'h00000000, 4'hF);
    chk(rd, 8'h10);
    chk(avs_readdata_o[15:8], 8'h00);
    bus(1'b0, ACF_OFS_OPA, 32'h00000000, 4'hF);
    chk(rd, 8'hA5);
    bus(1'b0, ACF_OFS_OPB, 32'h00000000, 4'hF);
    chk(rd, 8'h5A);
    // Direct write: top three bits always read zero
    bus(1'b1, ACF_OFS_FLAGS, 32'h000000FF, 4'hF);
    bus(1'b0, ACF_OFS_FLAGS, 32'h00000000, 4'hF);
    chk(rd, 8'h1F);
    bus(1'b1, ACF_OFS_FLAGS, 32'h00000000, 4'h0);
    chk(flags_o, 8'h1F);
    bus(1'b1, 4'h2, 32'h000000FF, 4'hF);
    bus(1'b0, 4'h2, 32'h00000000, 4'hF);
    chk(rd, 8'h00);
    chk(flags_o, 8'h1F);
    $display("Register access test done");
    // Reset in mid-run clears the flags
    rst_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk(flags_o, 8'h00);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    // First request straight after release must still land
    bus(1'b1, ACF_OFS_FLAGS, 32'h00000015, 4'hF);
    chk(flags_o, 8'h15);
    $display("Mid-run reset test done");
    end_sim();
  end
endmodule
